// >>> bsfo_core.v
// Bit, shift and flag execution datapath with its working and I/O registers, behind APB.
// Assumes one clock mclk and a synchronous active-high reset srst from the host core.
`timescale 1ns/1ps
`include "bsfo_map.vh"

module bsfo_core #(
  parameter REG_AW = 5,
  parameter IO_AW  = 5
) (
  input  wire        mclk,
  input  wire        srst,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output wire        pslverr,
  output reg  [31:0] prdata,
  output wire        busy,
  output wire [7:0]  statusFlags
);

  localparam ST_IDLE  = 2'h0;
  localparam ST_READ  = 2'h1;
  localparam ST_EXEC  = 2'h2;
  localparam ST_EXEC2 = 2'h3;

  // Decodes a three-bit index into a one-hot mask.
  function [7:0] bitMask;
    input [2:0] idx;
    begin
      bitMask = 8'h01 << idx;
    end
  endfunction

  // Forces one bit of a byte to a given value.
  function [7:0] putBit;
    input [7:0] val;
    input [2:0] idx;
    input       bitVal;
    begin
      putBit = bitVal ? (val | bitMask(idx)) : (val & ~bitMask(idx));
    end
  endfunction

  reg  [1:0]        state_q;
  reg  [1:0]        state_d;
  reg  [3:0]        op_q;
  reg  [REG_AW-1:0] rdIdx_q;
  reg  [IO_AW-1:0]  rrIdx_q;
  reg  [2:0]        bitIdx_q;
  reg  [7:0]        flags_q;
  reg  [7:0]        flags_d;
  reg  [7:0]        stack_q;
  reg  [REG_AW-1:0] sel_q;
  reg  [7:0]        result_q;
  reg  [7:0]        result_d;
  reg  [7:0]        hold_q;
  reg  [7:0]        hold_d;
  reg               rdWait_q;
  reg               wasIdle_q;

  wire [7:0]        wregRd;
  wire [7:0]        ioRd;
  reg               wregWe;
  reg  [REG_AW-1:0] wregWa;
  reg  [7:0]        wregWd;
  reg               ioWe;
  reg  [IO_AW-1:0]  ioWa;
  reg  [7:0]        ioWd;
  wire [REG_AW-1:0] wregRa;
  wire [IO_AW-1:0]  ioRa;

  wire        apbWr     = psel & penable & pwrite;
  wire        apbRd     = psel & penable & ~pwrite;
  wire        hitCtrl   = (paddr == `BSFO_OFF_CTRL);
  wire        hitStatus = (paddr == `BSFO_OFF_STATUS);
  wire        hitFlags  = (paddr == `BSFO_OFF_FLAGS);
  wire        hitStack  = (paddr == `BSFO_OFF_STACK);
  wire        hitSel    = (paddr == `BSFO_OFF_SEL);
  wire        hitWreg   = (paddr == `BSFO_OFF_WREG);
  wire        hitIoreg  = (paddr == `BSFO_OFF_IOREG);
  wire        hitResult = (paddr == `BSFO_OFF_RESULT);
  wire        mapped    = hitCtrl | hitStatus | hitFlags | hitStack | hitSel |
                          hitWreg | hitIoreg | hitResult;
  wire        memRead   = ~pwrite & (hitWreg | hitIoreg);
  wire        idle      = (state_q == ST_IDLE);

  wire [3:0]  newOp     = pwdata[`BSFO_CTRL_OP_MSB:`BSFO_CTRL_OP_LSB];
  wire        opValid   = (newOp <= `BSFO_OP_TRANSFER_FLAG_TO_BIT);
  wire        launch    = apbWr & hitCtrl & idle & opValid;
  wire        needRead  = (newOp != `BSFO_OP_POP) & (newOp != `BSFO_OP_FSET) &
                          (newOp != `BSFO_OP_FCLR);
  wire        rdOpd     = (op_q == `BSFO_OP_BIT_TO_TRANSFER_FLAG);
  // A window read is captured only after a full idle cycle, so the registered memory
  // output already shows the selected entry and the last write of an operation.
  wire        memFetch  = apbRd & memRead & idle & wasIdle_q & ~rdWait_q;

  // Memory reads take one extra access cycle, and wait while an operation runs.
  assign pready  = ~memRead | (rdWait_q & idle);
  assign pslverr = psel & penable & pready & ~mapped;
  assign busy    = ~idle;
  assign statusFlags = flags_q;

  // Operand fetch address: the source register for bit store, else the destination.
  assign wregRa = idle ? sel_q : (rdOpd ? rrIdx_q[REG_AW-1:0] : rdIdx_q);
  assign ioRa   = idle ? sel_q[IO_AW-1:0] : rrIdx_q;

  bsfo_mem #(
    .AW (REG_AW),
    .DW (8)
  ) uWorkRegs (
    .mclk   (mclk),
    .wrEn   (wregWe),
    .wrAddr (wregWa),
    .wrData (wregWd),
    .rdAddr (wregRa),
    .rdData (wregRd)
  );

  bsfo_mem #(
    .AW (IO_AW),
    .DW (8)
  ) uIoRegs (
    .mclk   (mclk),
    .wrEn   (ioWe),
    .wrAddr (ioWa),
    .wrData (ioWd),
    .rdAddr (ioRa),
    .rdData (ioRd)
  );

  // Sequencing of an operation through fetch and execution.
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (launch) begin
          state_d = needRead ? ST_READ : ST_EXEC;
        end
      end
      ST_READ: begin
        state_d = ST_EXEC;
      end
      ST_EXEC: begin
        if ((op_q == `BSFO_OP_POP) || (op_q == `BSFO_OP_IOSET) ||
            (op_q == `BSFO_OP_IOCLR)) begin
          state_d = ST_EXEC2;
        end else begin
          state_d = ST_IDLE;
        end
      end
      ST_EXEC2: begin
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // Result and flag computation in the execution cycle.
  always @* begin
    result_d = result_q;
    flags_d  = flags_q;
    hold_d   = hold_q;
    wregWe   = 1'b0;
    wregWa   = rdIdx_q;
    wregWd   = 8'h00;
    ioWe     = 1'b0;
    ioWa     = rrIdx_q;
    ioWd     = hold_q;
    if (state_q == ST_EXEC) begin
      case (op_q)
        `BSFO_OP_POP: begin
          hold_d = stack_q;
        end
        `BSFO_OP_IOSET: begin
          hold_d = putBit(ioRd, bitIdx_q, 1'b1);
        end
        `BSFO_OP_IOCLR: begin
          hold_d = putBit(ioRd, bitIdx_q, 1'b0);
        end
        `BSFO_OP_SHIFT_LEFT_LOGICAL: begin
          result_d = {wregRd[6:0], 1'b0};
          flags_d[`BSFO_FLAG_C] = wregRd[7];
        end
        `BSFO_OP_SHIFT_RIGHT_LOGICAL: begin
          result_d = {1'b0, wregRd[7:1]};
          flags_d[`BSFO_FLAG_C] = wregRd[0];
        end
        `BSFO_OP_ROTATE_LEFT_CARRY: begin
          result_d = {wregRd[6:0], flags_q[`BSFO_FLAG_C]};
          flags_d[`BSFO_FLAG_C] = wregRd[7];
        end
        `BSFO_OP_ROTATE_RIGHT_CARRY: begin
          result_d = {flags_q[`BSFO_FLAG_C], wregRd[7:1]};
          flags_d[`BSFO_FLAG_C] = wregRd[0];
        end
        `BSFO_OP_SHIFT_RIGHT_ARITH: begin
          result_d = {wregRd[7], wregRd[7:1]};
          flags_d[`BSFO_FLAG_C] = wregRd[0];
        end
        `BSFO_OP_SWAP: begin
          result_d = {wregRd[3:0], wregRd[7:4]};
        end
        `BSFO_OP_FSET: begin
          flags_d = putBit(flags_q, bitIdx_q, 1'b1);
        end
        `BSFO_OP_FCLR: begin
          flags_d = putBit(flags_q, bitIdx_q, 1'b0);
        end
        `BSFO_OP_BIT_TO_TRANSFER_FLAG: begin
          flags_d[`BSFO_FLAG_T] = wregRd[bitIdx_q];
        end
        `BSFO_OP_TRANSFER_FLAG_TO_BIT: begin
          result_d = putBit(wregRd, bitIdx_q, flags_q[`BSFO_FLAG_T]);
        end
        default: begin
          result_d = result_q;
        end
      endcase
      // Shift and rotate results also set zero, negative and overflow.
      if ((op_q >= `BSFO_OP_SHIFT_LEFT_LOGICAL) && (op_q <= `BSFO_OP_SHIFT_RIGHT_ARITH)) begin
        flags_d[`BSFO_FLAG_Z] = (result_d == 8'h00);
        flags_d[`BSFO_FLAG_N] = result_d[7];
        flags_d[`BSFO_FLAG_V] = result_d[7] ^ flags_d[`BSFO_FLAG_C];
      end
      if (((op_q >= `BSFO_OP_SHIFT_LEFT_LOGICAL) && (op_q <= `BSFO_OP_SWAP)) ||
          (op_q == `BSFO_OP_TRANSFER_FLAG_TO_BIT)) begin
        wregWe = 1'b1;
        wregWd = result_d;
      end
    end else if (state_q == ST_EXEC2) begin
      if (op_q == `BSFO_OP_POP) begin
        wregWe   = 1'b1;
        wregWd   = hold_q;
        result_d = hold_q;
      end else begin
        ioWe     = 1'b1;
        ioWd     = hold_q;
        result_d = hold_q;
      end
    end else if (idle && apbWr) begin
      // Software access to the register windows while no operation runs.
      if (hitWreg) begin
        wregWe = 1'b1;
        wregWa = sel_q;
        wregWd = pwdata[7:0];
      end
      if (hitIoreg) begin
        ioWe = 1'b1;
        ioWa = sel_q[IO_AW-1:0];
        ioWd = pwdata[7:0];
      end
      if (hitFlags) begin
        flags_d = pwdata[7:0];
      end
    end
  end

  always @(posedge mclk) begin
    if (srst) begin
      state_q  <= ST_IDLE;
      op_q     <= 4'h0;
      rdIdx_q  <= {REG_AW{1'b0}};
      rrIdx_q  <= {IO_AW{1'b0}};
      bitIdx_q <= 3'h0;
      flags_q  <= `BSFO_FLAGS_RESET;
      stack_q  <= `BSFO_STACK_RESET;
      sel_q    <= {REG_AW{1'b0}};
      result_q <= 8'h00;
      hold_q   <= 8'h00;
      rdWait_q <= 1'b0;
      wasIdle_q <= 1'b1;
    end else begin
      state_q  <= state_d;
      flags_q  <= flags_d;
      result_q <= result_d;
      hold_q   <= hold_d;
      rdWait_q <= memFetch;
      wasIdle_q <= idle;
      if (launch) begin
        op_q     <= newOp;
        rdIdx_q  <= pwdata[`BSFO_CTRL_RD_LSB +: REG_AW];
        rrIdx_q  <= pwdata[`BSFO_CTRL_RR_LSB +: IO_AW];
        bitIdx_q <= pwdata[`BSFO_CTRL_BIT_MSB:`BSFO_CTRL_BIT_LSB];
      end
      if (apbWr && idle && hitStack) begin
        stack_q <= pwdata[7:0];
      end
      if (apbWr && idle && hitSel) begin
        sel_q <= pwdata[REG_AW-1:0];
      end
    end
  end

  // Read data mux; registered so the data output comes from a flip-flop.
  always @(posedge mclk) begin
    if (srst) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= 32'h00000000;
      if (hitCtrl) begin
        prdata <= {5'h00, bitIdx_q, {(8 - IO_AW){1'b0}}, rrIdx_q,
                   {(8 - REG_AW){1'b0}}, rdIdx_q, 4'h0, op_q};
      end
      if (hitStatus) begin
        prdata <= {16'h0000, flags_q, 7'h00, ~idle};
      end
      if (hitFlags) begin
        prdata <= {24'h000000, flags_q};
      end
      if (hitStack) begin
        prdata <= {24'h000000, stack_q};
      end
      if (hitSel) begin
        prdata <= {{(32 - REG_AW){1'b0}}, sel_q};
      end
      if (hitResult) begin
        prdata <= {24'h000000, result_q};
      end
    end else if (memFetch) begin
      // Window data is taken at the end of the first access cycle that follows a full idle cycle, on the same edge that raises pready.
      prdata <= hitWreg ? {24'h000000, wregRd} : {24'h000000, ioRd};
    end
  end

endmodule // bsfo_core

// >>> bsfo_core_checker.sv
// Concurrent checks on the ports of the bit, shift and flag datapath.
// Assumes one clock mclk and a synchronous active-high reset srst; bound to bsfo_core.
`timescale 1ns/1ps
`include "bsfo_map.vh"

module bsfo_core_checker (
  input logic        mclk,
  input logic        srst,
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [11:0] paddr,
  input logic [31:0] pwdata,
  input logic        pready,
  input logic        pslverr,
  input logic [31:0] prdata,
  input logic        busy,
  input logic [7:0]  statusFlags
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  // A launch is a CTRL write accepted while the datapath is idle.
  wire       ctrlWr = psel && penable && pwrite && pready && !busy
                      && (paddr == `BSFO_OFF_CTRL);
  wire [3:0] opc    = pwdata[3:0];
  wire [2:0] bitIdx = pwdata[26:24];

  pop_time_a: assert property (ctrlWr && opc == 4'h0 |=> busy [*2] ##1 !busy)
    else $error("pop did not take two cycles");
  io_time_a: assert property (ctrlWr && opc inside {4'h1, 4'h2} |=> busy [*3] ##1 !busy)
    else $error("io bit op did not take its cycles");
  alu_time_a: assert property (ctrlWr && opc inside {[4'h3:4'h8], 4'hB, 4'hC}
    |=> busy [*2] ##1 !busy)
    else $error("shift or bit op did not take its cycles");
  flag_time_a: assert property (ctrlWr && opc inside {4'h9, 4'hA} |=> busy ##1 !busy)
    else $error("flag op did not take one cycle");
  keep_flags_a: assert property (ctrlWr && opc inside {4'h0, 4'h1, 4'h2, 4'h8, 4'hC}
    |=> $stable(statusFlags) [*3])
    else $error("flags changed on a flag-neutral op");
  flag_set_a: assert property (ctrlWr && opc == 4'h9 |-> ##2
    statusFlags == ($past(statusFlags, 2) | (8'h01 << $past(bitIdx, 2))))
    else $error("flag set result wrong");
  flag_clr_a: assert property (ctrlWr && opc == 4'hA |-> ##2
    statusFlags == ($past(statusFlags, 2) & ~(8'h01 << $past(bitIdx, 2))))
    else $error("flag clear result wrong");
  store_only_t_a: assert property (ctrlWr && opc == 4'hB |-> ##3
    (statusFlags & 8'hBF) == ($past(statusFlags, 3) & 8'hBF))
    else $error("bit store changed another flag");
  shift_flags_a: assert property (ctrlWr && opc inside {[4'h3:4'h7]} |-> ##3
    statusFlags[3] == (statusFlags[2] ^ statusFlags[0])
    && (statusFlags & 8'hF0) == ($past(statusFlags, 3) & 8'hF0))
    else $error("shift flag update wrong");

  cover property (ctrlWr && opc == 4'h1);
  cover property (ctrlWr && opc == 4'h9);
  cover property (psel && penable && pready && pslverr);
  cover property (ctrlWr && opc inside {[4'h3:4'h7]});
  cover property (psel && penable && !pwrite && !pready);
endmodule // bsfo_core_checker

bind bsfo_core bsfo_core_checker chk_u (
  .mclk(mclk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
  .prdata(prdata), .busy(busy), .statusFlags(statusFlags)
);

// >>> bsfo_map.vh
// Register offsets, field positions, opcodes and reset values of the bit, shift and flag datapath.
// Assumes a 32-bit APB slave with byte addresses; included by bare name.
`ifndef BSFO_MAP_VH
`define BSFO_MAP_VH

`define BSFO_OFF_CTRL     12'h000
`define BSFO_OFF_STATUS   12'h004
`define BSFO_OFF_FLAGS    12'h008
`define BSFO_OFF_STACK    12'h00C
`define BSFO_OFF_SEL      12'h010
`define BSFO_OFF_WREG     12'h014
`define BSFO_OFF_IOREG    12'h018
`define BSFO_OFF_RESULT   12'h01C

`define BSFO_CTRL_OP_LSB  0
`define BSFO_CTRL_OP_MSB  3
`define BSFO_CTRL_RD_LSB  8
`define BSFO_CTRL_RD_MSB  12
`define BSFO_CTRL_RR_LSB  16
`define BSFO_CTRL_RR_MSB  20
`define BSFO_CTRL_BIT_LSB 24
`define BSFO_CTRL_BIT_MSB 26

`define BSFO_OP_POP                   4'h0
`define BSFO_OP_IOSET                 4'h1
`define BSFO_OP_IOCLR                 4'h2
`define BSFO_OP_SHIFT_LEFT_LOGICAL    4'h3
`define BSFO_OP_SHIFT_RIGHT_LOGICAL   4'h4
`define BSFO_OP_ROTATE_LEFT_CARRY     4'h5
`define BSFO_OP_ROTATE_RIGHT_CARRY    4'h6
`define BSFO_OP_SHIFT_RIGHT_ARITH     4'h7
`define BSFO_OP_SWAP                  4'h8
`define BSFO_OP_FSET                  4'h9
`define BSFO_OP_FCLR                  4'hA
`define BSFO_OP_BIT_TO_TRANSFER_FLAG  4'hB
`define BSFO_OP_TRANSFER_FLAG_TO_BIT  4'hC

`define BSFO_FLAG_C       0
`define BSFO_FLAG_Z       1
`define BSFO_FLAG_N       2
`define BSFO_FLAG_V       3
`define BSFO_FLAG_T       6

`define BSFO_FLAGS_RESET  8'h00
`define BSFO_STACK_RESET  8'h00

`endif

// >>> bsfo_mem.v
// Small single-write-port memory with a registered read port.
// Assumes one clock; contents are not reset.
`timescale 1ns/1ps

module bsfo_mem #(
  parameter AW = 5,
  parameter DW = 8
) (
  input  wire          mclk,
  input  wire          wrEn,
  input  wire [AW-1:0] wrAddr,
  input  wire [DW-1:0] wrData,
  input  wire [AW-1:0] rdAddr,
  output reg  [DW-1:0] rdData
);

  reg [DW-1:0] store [0:(1<<AW)-1];

  always @(posedge mclk) begin
    if (wrEn) begin
      store[wrAddr] <= wrData;
    end
    rdData <= store[rdAddr];
  end

endmodule // bsfo_mem

// >>> tb_bit_shift_flag_ops.sv
// Self-checking bench for the bit, shift and flag datapath, driven over APB.
// Assumes bsfo_core with default parameters and the checker bound to it.
`timescale 1ns/1ps
`include "bsfo_map.vh"

module tb_bit_shift_flag_ops;
  logic        mclk;
  logic        srst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  wire         pready;
  wire         pslverr;
  wire  [31:0] prdata;
  wire         busy;
  wire  [7:0]  statusFlags;
  int          error_cnt;
  int          checked;
  logic [32:0] expQ[$];
  logic [7:0]  lastRes;
  logic [31:0] lastCtrl;

  bsfo_core dut_u (
    .mclk(mclk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .busy(busy), .statusFlags(statusFlags)
  );

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  task automatic end_of_test;
    // An expectation left over means a read never completed.
    if (expQ.size() != 0)
      error_cnt++;
    if (error_cnt == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic check_flags(input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t flags exp=%h got=%h", $time, exp, got);
    end
  endtask

  task automatic check_data(input logic [32:0] exp, input logic [32:0] got);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask

  // Each completed read takes the oldest expectation off the queue.
  always @(posedge mclk)
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0) begin
      if (paddr == `BSFO_OFF_FLAGS && expQ.size() > 0)
        check_flags(expQ[0][7:0], statusFlags);
      check_data(expQ.size() > 0 ? expQ.pop_front() : 33'h1FFFFFFFF,
                 {pslverr, prdata});
    end

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1 && n < 100) begin
      n++;
      @(posedge mclk);
    end
    if (n >= 100)
      error_cnt++;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    logic bad;
    bad = (a[1:0] != 2'h0) || (a > `BSFO_OFF_RESULT);
    expQ.push_back({bad, e});
    apb(1'b0, a, 32'h00000000);
  endtask

  task automatic run_op(input logic [3:0] op);
    logic [7:0]  v, f, stk, r, io, fe;
    logic [4:0]  idx;
    logic [2:0]  b;
    logic        c;
    logic [31:0] cw;
    int          n;
    v   = 8'($urandom);
    f   = 8'($urandom);
    stk = 8'($urandom);
    idx = 5'($urandom);
    b   = 3'($urandom);
    r   = v;
    io  = v;
    fe  = f;
    c   = 1'b0;
    n   = 0;
    cw  = {5'h00, b, 3'h0, idx, 3'h0, idx, 4'h0, op};
    case (op)
      `BSFO_OP_POP:                  r = stk;
      `BSFO_OP_IOSET:                io = v | (8'h01 << b);
      `BSFO_OP_IOCLR:                io = v & ~(8'h01 << b);
      `BSFO_OP_SHIFT_LEFT_LOGICAL:   {c, r} = {v, 1'b0};
      `BSFO_OP_SHIFT_RIGHT_LOGICAL:  {r, c} = {1'b0, v};
      `BSFO_OP_ROTATE_LEFT_CARRY:    {c, r} = {v, f[0]};
      `BSFO_OP_ROTATE_RIGHT_CARRY:   {r, c} = {f[0], v};
      `BSFO_OP_SHIFT_RIGHT_ARITH:    {r, c} = {v[7], v};
      `BSFO_OP_SWAP:                 r = {v[3:0], v[7:4]};
      `BSFO_OP_FSET:                 fe[b] = 1'b1;
      `BSFO_OP_FCLR:                 fe[b] = 1'b0;
      `BSFO_OP_BIT_TO_TRANSFER_FLAG: fe[6] = v[b];
      `BSFO_OP_TRANSFER_FLAG_TO_BIT: r[b] = f[6];
      default:                       ;
    endcase
    if (op >= `BSFO_OP_SHIFT_LEFT_LOGICAL && op <= `BSFO_OP_SHIFT_RIGHT_ARITH)
      fe[3:0] = {r[7] ^ c, r[7], r == 8'h00, c};
    // Only accepted operations change the control readback and the last result.
    if (op <= `BSFO_OP_TRANSFER_FLAG_TO_BIT)
      lastCtrl = cw;
    if (op <= `BSFO_OP_SWAP || op == `BSFO_OP_TRANSFER_FLAG_TO_BIT)
      lastRes = (op == `BSFO_OP_IOSET || op == `BSFO_OP_IOCLR) ? io : r;
    apb(1'b1, `BSFO_OFF_SEL, {27'h0, idx});
    apb(1'b1, `BSFO_OFF_WREG, {24'h0, v});
    apb(1'b1, `BSFO_OFF_IOREG, {24'h0, v});
    apb(1'b1, `BSFO_OFF_STACK, {24'h0, stk});
    apb(1'b1, `BSFO_OFF_FLAGS, {24'h0, f});
    apb(1'b1, `BSFO_OFF_CTRL, cw);
    // A flags write during a long op must be ignored.
    if (op == `BSFO_OP_IOSET || op == `BSFO_OP_IOCLR)
      apb(1'b1, `BSFO_OFF_FLAGS, {24'h0, ~f});
    while (busy !== 1'b0 && n < 20) begin
      n++;
      @(posedge mclk);
    end
    rd(`BSFO_OFF_WREG, {24'h0, r});
    rd(`BSFO_OFF_IOREG, {24'h0, io});
    if (n >= 20)
      error_cnt++;
    rd(`BSFO_OFF_FLAGS, {24'h0, fe});
    rd(`BSFO_OFF_STATUS, {16'h0000, fe, 8'h00});
    rd(`BSFO_OFF_RESULT, {24'h0, lastRes});
    rd(`BSFO_OFF_CTRL, lastCtrl);
  endtask

  initial begin
    srst      = 1'b1;
    psel      = 1'b0;
    penable   = 1'b0;
    pwrite    = 1'b0;
    paddr     = 12'h000;
    pwdata    = 32'h00000000;
    error_cnt = 0;
    checked   = 0;
    lastRes   = 8'h00;
    lastCtrl  = 32'h00000000;
    void'($urandom(18693));
    repeat (8) @(posedge mclk);
    srst <= 1'b0;
    @(posedge mclk);
    rd(`BSFO_OFF_FLAGS, 32'h00000000);
    // Unmapped address reads back zero.
    rd(12'h020, 32'h00000000);
    for (int k = 0; k < 64; k++)
      run_op(4'(k % 16));
    end_of_test;
  end

  initial begin
    repeat (20000) @(posedge mclk);
    error_cnt++;
    end_of_test;
  end
endmodule // tb_bit_shift_flag_ops
